// ===== lmfr_host.sv
/*
 * host model for the led matrix function register bank: one-cycle
 * write and read strobes, read data taken one cycle after the strobe.
 * assumes the bank's clock and its registered read answer.
 */
`include "lmfr_params.svh"
`timescale 1ns/10ps
`default_nettype none
module lmfr_host
    import lmfr_pkg::*;
(
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    output lmfr_req_t req_o
);
    // idle bus at start
    initial begin
        req_o = '0;
    end
    // one write strobe; payload inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // one read strobe; data sampled once the answering edge has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
        @(posedge clock_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
        #1;
        d = rdata_i;
    endtask
    // one detection pass: current level, clear, trigger, then wait it out
    task automatic detect(input logic [1:0] code);
        wr(`LMFR_OFS_GCC, 8'h0F);
        wr(`LMFR_OFS_CFG, 8'h09);
        wr(`LMFR_OFS_CFG, {5'h01, code, 1'b1});
        repeat (40 * (`LMFR_SLOT_CYC + `LMFR_GAP_CYC + `LMFR_DLY_CYC)) @(posedge clock_i);
    endtask
endmodule
`default_nettype wire

// ===== lmfr_params.svh
/*
 * offsets, field positions, reset values and timing counts of the
 * led matrix function register bank.
 * assumes a 25 MHz core clock; included by its bare name.
 */
`ifndef LMFR_PARAMS_SVH
`define LMFR_PARAMS_SVH

`define LMFR_CLK_MHZ 25
`define LMFR_OFS_CFG 8'h00
`define LMFR_OFS_GCC 8'h01
`define LMFR_OFS_PULL 8'h02
`define LMFR_OFS_RES_FIRST 8'h03
`define LMFR_OFS_RES_LAST 8'h23
`define LMFR_OFS_THERM 8'h24
`define LMFR_OFS_CLK 8'h25
`define LMFR_OFS_SRST 8'h2F
`define LMFR_SRST_MAGIC 8'hAE
`define LMFR_RST_PULL 8'h33
`define LMFR_RST_ZERO 8'h00
`define LMFR_PULL_MASK 8'hF7
`define LMFR_THERM_MASK 8'h0F
`define LMFR_CLK_MASK 8'hDF
`define LMFR_RES_MASK 8'h3F
`define LMFR_DET_OPEN 2'h1
`define LMFR_DET_SHORT 2'h2
`define LMFR_SYNC_SLAVE 2'h2
`define LMFR_SYNC_MASTER 2'h3
// scan timing, in nanoseconds
`define LMFR_SCAN_SLOT_NS 33000
`define LMFR_SCAN_GAP_NS 830
`define LMFR_SINK_DELAY_NS 300
`define LMFR_NS_PER_CYC (1000 / `LMFR_CLK_MHZ)
// least times round up
`define LMFR_SLOT_CYC ((`LMFR_SCAN_SLOT_NS + `LMFR_NS_PER_CYC - 1) / `LMFR_NS_PER_CYC)
`define LMFR_GAP_CYC ((`LMFR_SCAN_GAP_NS + `LMFR_NS_PER_CYC - 1) / `LMFR_NS_PER_CYC)
`define LMFR_DLY_CYC ((`LMFR_SINK_DELAY_NS + `LMFR_NS_PER_CYC - 1) / `LMFR_NS_PER_CYC)

`endif

// ===== lmfr_pkg.sv
/*
 * types of the led matrix function register bank.
 * assumes lmfr_params.svh for the numbers.
 */
package lmfr_pkg;
    // scan sequencer states, one-hot
    typedef enum logic [2:0] {
        LMFR_SLOT = 3'b001,
        LMFR_GAP = 3'b010,
        LMFR_DLY = 3'b100
    } lmfr_scan_t;

    // host register write and read port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lmfr_req_t;

    // analog controls decoded from the registers
    typedef struct packed {
        logic phase_180;
        logic [2:0] scan_line_pulldown_sel;
        logic [2:0] sink_line_pullup_sel;
        logic [1:0] thermal_threshold;
        logic [1:0] thermal_derate_level;
        logic spread_enable;
        logic [1:0] spread_range;
        logic [1:0] spread_cycle_time;
    } lmfr_analog_t;
endpackage

// ===== lmfr_regs.sv
/*
 * function register bank, scan sequencer and duty generator of an led
 * matrix driver. the serial decoder in front delivers one-cycle read and
 * write strobes on clock_i; detection comparators and the sync pin arrive
 * from outside the clock domain and are synchronised here.
 */
`include "lmfr_params.svh"
`timescale 1ns/10ps
`default_nettype none

module lmfr_regs
    import lmfr_pkg::*;
#(
    parameter int SCAN_LINES = 11,
    parameter int SINK_LINES = 6,
    parameter int RES_WORDS = 33
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire lmfr_req_t req_i,
    input wire logic [SINK_LINES-1:0] fault_sense_i,
    input wire logic sync_in_i,
    input wire logic [7:0] duty_i,
    output logic [7:0] rdata_o,
    output logic [SCAN_LINES-1:0] scan_line_o,
    output logic [SINK_LINES-1:0] sink_line_o,
    output lmfr_analog_t analog_o,
    output logic sync_out_o,
    output logic sync_oe_o,
    output logic sync_pulldown_o
);
    // elaboration check of the supported sizes
    if (SCAN_LINES < 1 || SCAN_LINES > 16
        || SINK_LINES != 6 || RES_WORDS != 33) begin : g_bad_size
        $error("lmfr_regs: unsupported parameters");
    end

    logic [7:0] cfg, global_current_level, pull, therm, clkc;
    logic [7:0] res_mem [RES_WORDS];
    logic [1:0] det_prev;
    logic [5:0] det_idx;
    logic det_busy, det_is_short;
    logic [SINK_LINES-1:0] fs_a, fs_b;
    logic sy_a, sy_b, sy_c;
    lmfr_scan_t state;
    logic [10:0] tcnt;
    logic [3:0] line;
    logic [7:0] rdata_nx;

    // host strobe decode
    wire logic wr_cfg = req_i.wr && req_i.addr == `LMFR_OFS_CFG;
    wire logic wr_gcc = req_i.wr && req_i.addr == `LMFR_OFS_GCC;
    wire logic wr_pull = req_i.wr && req_i.addr == `LMFR_OFS_PULL;
    wire logic wr_therm = req_i.wr && req_i.addr == `LMFR_OFS_THERM;
    wire logic wr_clk = req_i.wr && req_i.addr == `LMFR_OFS_CLK;
    wire logic soft_rst = req_i.wr && req_i.addr == `LMFR_OFS_SRST
        && req_i.wdata == `LMFR_SRST_MAGIC;
    wire logic in_res = req_i.addr >= `LMFR_OFS_RES_FIRST && req_i.addr <= `LMFR_OFS_RES_LAST;
    wire logic [5:0] res_sel = 6'(req_i.addr - `LMFR_OFS_RES_FIRST);

    // detection trigger on a 00 to 01 or 10 change
    wire logic [1:0] fault_detect_trigger = cfg[2:1];
    wire logic det_start = !det_busy && det_prev == 2'h0
        && (fault_detect_trigger == `LMFR_DET_OPEN || fault_detect_trigger == `LMFR_DET_SHORT);
    wire logic [1:0] sync_mode = clkc[7:6];
    wire logic slave = sync_mode == `LMFR_SYNC_SLAVE;
    // slave timing advances only on sync rising edges
    wire logic tick = slave ? (sy_b && !sy_c) : 1'b1;
    wire logic tend = tcnt == 11'd0;
    wire logic line_last = line == 4'(SCAN_LINES - 1);
    wire logic [10:0] duty_cyc = 11'((32'(duty_i) * `LMFR_SLOT_CYC) / 256);
    // first slot cycle counts as zero used, so duty spans exactly duty_cyc
    wire logic [10:0] slot_used = 11'(`LMFR_SLOT_CYC - 1) - tcnt;

    // read mux; reserved bits masked, unmapped reads zero
    always_comb begin
        rdata_nx = 8'h00;
        if (req_i.addr == `LMFR_OFS_CFG) rdata_nx = cfg;
        else if (req_i.addr == `LMFR_OFS_GCC) rdata_nx = global_current_level;
        else if (req_i.addr == `LMFR_OFS_PULL) rdata_nx = pull;
        else if (in_res) rdata_nx = res_mem[res_sel] & `LMFR_RES_MASK;
        else if (req_i.addr == `LMFR_OFS_THERM) rdata_nx = therm;
        else if (req_i.addr == `LMFR_OFS_CLK) rdata_nx = clkc;
    end

    // control registers, power-up and magic soft reset
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg <= `LMFR_RST_ZERO;
            global_current_level <= `LMFR_RST_ZERO;
            pull <= `LMFR_RST_PULL;
            therm <= `LMFR_RST_ZERO;
            clkc <= `LMFR_RST_ZERO;
        end else if (soft_rst) begin
            cfg <= `LMFR_RST_ZERO;
            global_current_level <= `LMFR_RST_ZERO;
            pull <= `LMFR_RST_PULL;
            therm <= `LMFR_RST_ZERO;
            clkc <= `LMFR_RST_ZERO;
        end else begin
            if (wr_cfg) cfg <= req_i.wdata;
            if (wr_gcc) global_current_level <= req_i.wdata;
            if (wr_pull) pull <= req_i.wdata & `LMFR_PULL_MASK;
            if (wr_therm) therm <= req_i.wdata & `LMFR_THERM_MASK;
            if (wr_clk) clkc <= req_i.wdata & `LMFR_CLK_MASK;
        end
    end

    // two-stage synchronisers for pins
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fs_a <= '0;
            fs_b <= '0;
            sy_a <= 1'b0;
            sy_b <= 1'b0;
            sy_c <= 1'b0;
        end else begin
            fs_a <= fault_sense_i;
            fs_b <= fs_a;
            sy_a <= sync_in_i;
            sy_b <= sy_a;
            sy_c <= sy_b;
        end
    end

    // one-off detection pass, one result word per scan slot
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            det_prev <= 2'h0;
            det_busy <= 1'b0;
            det_is_short <= 1'b0;
            det_idx <= 6'h00;
        end else if (soft_rst) begin
            det_prev <= 2'h0;
            det_busy <= 1'b0;
            det_idx <= 6'h00;
        end else begin
            det_prev <= fault_detect_trigger;
            if (det_start) begin
                det_busy <= 1'b1;
                det_is_short <= fault_detect_trigger == `LMFR_DET_SHORT;
                det_idx <= 6'h00;
            end else if (det_busy && tick && state == LMFR_SLOT && tend) begin
                det_idx <= det_idx + 6'h01;
                if (det_idx == 6'(RES_WORDS - 1)) det_busy <= 1'b0;
            end
        end
    end

    // result store; host writes never reach it, power-up clears it
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int w = 0; w < RES_WORDS; w++) begin
                res_mem[w] <= 8'h00;
            end
        end else if (det_busy && tick && state == LMFR_SLOT && tend) begin
            res_mem[det_idx] <= {2'b00, fs_b};
        end
    end

    // scan sequencer: slot, non-overlap gap, sink delay
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= LMFR_SLOT;
            tcnt <= 11'(`LMFR_SLOT_CYC - 1);
            line <= 4'h0;
        end else if (tick) begin
            if (!tend) tcnt <= tcnt - 11'd1;
            else begin
                unique case (state)
                    LMFR_SLOT: begin
                        state <= LMFR_GAP;
                        tcnt <= 11'(`LMFR_GAP_CYC - 1);
                    end
                    LMFR_GAP: begin
                        state <= LMFR_DLY;
                        tcnt <= 11'(`LMFR_DLY_CYC - 1);
                    end
                    LMFR_DLY: begin
                        state <= LMFR_SLOT;
                        tcnt <= 11'(`LMFR_SLOT_CYC - 1);
                        line <= line_last ? 4'h0 : line + 4'h1;
                    end
                endcase
            end
        end
    end

    // registered outputs
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
            scan_line_o <= '0;
            sink_line_o <= '0;
            analog_o <= '0;
            sync_out_o <= 1'b0;
            sync_oe_o <= 1'b0;
            sync_pulldown_o <= 1'b1;
        end else begin
            rdata_o <= req_i.rd ? rdata_nx : 8'h00;
            scan_line_o <= (state == LMFR_SLOT) ? SCAN_LINES'(1) << line : '0;
            // sinks on while duty lasts; phase 180 puts the on-time at the end of the slot
            sink_line_o <= (state == LMFR_SLOT && cfg[0] &&
                (pull[7] ? (slot_used >= 11'(`LMFR_SLOT_CYC) - duty_cyc)
                         : (slot_used < duty_cyc))) ? '1 : '0;
            analog_o.phase_180 <= pull[7];
            analog_o.scan_line_pulldown_sel <= pull[6:4];
            analog_o.sink_line_pullup_sel <= pull[2:0];
            analog_o.thermal_threshold <= therm[3:2];
            analog_o.thermal_derate_level <= therm[1:0];
            analog_o.spread_enable <= clkc[4];
            analog_o.spread_range <= clkc[3:2];
            analog_o.spread_cycle_time <= clkc[1:0];
            sync_out_o <= sync_mode == `LMFR_SYNC_MASTER && state == LMFR_SLOT;
            sync_oe_o <= sync_mode == `LMFR_SYNC_MASTER;
            sync_pulldown_o <= !sync_mode[1];
        end
    end

    // gap length watch: ticks spent in the non-overlap gap
    logic [4:0] gap_ticks;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap_ticks <= 5'h00;
        end else if (state != LMFR_GAP) begin
            gap_ticks <= 5'h00;
        end else if (tick) begin
            gap_ticks <= gap_ticks + 5'h01;
        end
    end

    // checks
    a_soft_reset_pull: assert property (@(posedge clock_i) disable iff (!nrst_i)
        soft_rst |=> pull == `LMFR_RST_PULL && clkc == 8'h00)
        else $error("soft reset missed");
    a_pull_reserved: assert property (@(posedge clock_i) disable iff (!nrst_i)
        pull[3] == 1'b0)
        else $error("pull reserved bit set");
    a_phase_out: assert property (@(posedge clock_i) disable iff (!nrst_i)
        $changed(pull) |=> analog_o.phase_180 == $past(pull[7]))
        else $error("phase output stale");
    a_det_start: assert property (@(posedge clock_i) disable iff (!nrst_i)
        det_start && !soft_rst |=> det_busy && det_idx == 6'h00)
        else $error("detect not started");
    a_det_short: assert property (@(posedge clock_i) disable iff (!nrst_i)
        det_start && !soft_rst && fault_detect_trigger == `LMFR_DET_SHORT |=> det_is_short)
        else $error("short mode lost");
    a_sync_master: assert property (@(posedge clock_i) disable iff (!nrst_i)
        sync_mode == `LMFR_SYNC_MASTER && !soft_rst && !wr_clk
        |=> sync_oe_o && !sync_pulldown_o)
        else $error("master not driving");
    a_sync_off: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !sync_mode[1] && !wr_clk |=> !sync_oe_o && sync_pulldown_o)
        else $error("sync not held low");
    a_slave_hold: assert property (@(posedge clock_i) disable iff (!nrst_i)
        slave && !tick |=> $stable(tcnt) && $stable(state))
        else $error("slave ran without sync");
    a_gap_length: assert property (@(posedge clock_i) disable iff (!nrst_i)
        state == LMFR_GAP && tick && tend |-> gap_ticks == 5'(`LMFR_GAP_CYC - 1))
        else $error("gap length wrong");
    a_scan_blank: assert property (@(posedge clock_i) disable iff (!nrst_i)
        state != LMFR_SLOT |=> scan_line_o == '0)
        else $error("scan line high in gap");
    a_thermal_out: assert property (@(posedge clock_i) disable iff (!nrst_i)
        wr_therm && !soft_rst |=> ##1 analog_o.thermal_threshold == $past(therm[3:2])
        && analog_o.thermal_derate_level == $past(therm[1:0]))
        else $error("thermal fields stale");
    a_spread_out: assert property (@(posedge clock_i) disable iff (!nrst_i)
        wr_clk && !soft_rst |=> ##1 analog_o.spread_enable == $past(clkc[4])
        && analog_o.spread_range == $past(clkc[3:2])
        && analog_o.spread_cycle_time == $past(clkc[1:0]))
        else $error("spread fields stale");
    a_pulls_out: assert property (@(posedge clock_i) disable iff (!nrst_i)
        wr_pull && !soft_rst |=> ##1 analog_o.scan_line_pulldown_sel == $past(pull[6:4])
        && analog_o.sink_line_pullup_sel == $past(pull[2:0]))
        else $error("pull fields stale");
    c_open_pass: cover property (@(posedge clock_i) det_start && fault_detect_trigger == `LMFR_DET_OPEN);
    c_short_pass: cover property (@(posedge clock_i) det_start && fault_detect_trigger == `LMFR_DET_SHORT);
    c_soft_reset: cover property (@(posedge clock_i) soft_rst);
    c_line_wrap: cover property (@(posedge clock_i) line_last && state == LMFR_DLY && tend);
endmodule

`default_nettype wire

// ===== testbench.sv
/*
 * self-checking testbench of the led matrix function register bank.
 * assumes lmfr_host as the register master and the default scan sizes.
 */
`include "lmfr_params.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import lmfr_pkg::*;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [5:0] fault_sense_i = 6'h00;
    logic sync_in_i = 1'b0;
    logic [7:0] duty_i = 8'h00;
    lmfr_req_t req;
    logic [7:0] rdata;
    logic [10:0] scan_line;
    logic [5:0] sink_line;
    lmfr_analog_t analog;
    logic sync_out, sync_oe, sync_pd;
    int n_mismatch = 0;
    int checked = 0;
    // 25 MHz clock
    always #20 clock_i = ~clock_i;
    lmfr_host u_host (.clock_i(clock_i), .rdata_i(rdata), .req_o(req));
    lmfr_regs u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(req),
        .fault_sense_i(fault_sense_i), .sync_in_i(sync_in_i), .duty_i(duty_i),
        .rdata_o(rdata), .scan_line_o(scan_line), .sink_line_o(sink_line),
        .analog_o(analog), .sync_out_o(sync_out), .sync_oe_o(sync_oe),
        .sync_pulldown_o(sync_pd));
    // byte and count comparisons
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int lo, input int hi, input string what);
        checked++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s count %0d", $time, what, got);
        end
    endtask
    // settle past a clock edge
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // defaults after power-up
    task automatic t_defaults;
        logic [7:0] d;
        step(2);
        chk({2'b00, analog.scan_line_pulldown_sel, analog.sink_line_pullup_sel}, 8'h1B, "pull");
        chk({7'h00, sync_pd}, 8'h01, "sync pulldown");
        u_host.rd(`LMFR_OFS_PULL, d);
        chk(d, `LMFR_RST_PULL, "pull reset");
        u_host.rd(`LMFR_OFS_THERM, d);
        chk(d, 8'h00, "thermal reset");
        u_host.rd(`LMFR_OFS_CLK, d);
        chk(d, 8'h00, "clock reset");
        u_host.rd(8'h30, d);
        chk(d, 8'h00, "unmapped read");
        u_host.rd(`LMFR_OFS_RES_FIRST, d);
        chk(d, 8'h00, "result reset");
        $display("test defaults done");
    endtask
    // every pull, phase, thermal, sync and spread code
    task automatic t_fields;
        logic [7:0] d, v;
        for (int k = 0; k < 8; k++) begin
            v = {k[0], k[2:0], 1'b1, ~k[2:0]};
            u_host.wr(`LMFR_OFS_PULL, v);
            u_host.rd(`LMFR_OFS_PULL, d);
            chk(d, v & `LMFR_PULL_MASK, "pull readback");
            chk({analog.phase_180, analog.scan_line_pulldown_sel, 1'b0,
                analog.sink_line_pullup_sel}, v & `LMFR_PULL_MASK, "pull out");
        end
        for (int k = 0; k < 16; k++) begin
            u_host.wr(`LMFR_OFS_THERM, {4'hF, k[3:0]});
            u_host.rd(`LMFR_OFS_THERM, d);
            chk(d, {4'h0, k[3:0]}, "thermal readback");
            chk({4'h0, analog.thermal_threshold, analog.thermal_derate_level},
                {4'h0, k[3:0]}, "thermal out");
        end
        for (int k = 0; k < 4; k++) begin
            v = {k[1:0], 1'b1, k[0], k[1:0], ~k[1:0]};
            u_host.wr(`LMFR_OFS_CLK, v);
            u_host.rd(`LMFR_OFS_CLK, d);
            chk(d, v & `LMFR_CLK_MASK, "clock readback");
            chk({3'h0, analog.spread_enable, analog.spread_range, analog.spread_cycle_time},
                v & 8'h1F, "spread out");
            chk({6'h00, sync_oe, sync_pd}, {6'h00, k == 3, k < 2}, "sync mode");
        end
        $display("test fields done");
    endtask
    // magic value restores defaults
    task automatic t_soft_reset;
        logic [7:0] d;
        u_host.wr(`LMFR_OFS_PULL, 8'h80);
        u_host.wr(`LMFR_OFS_SRST, `LMFR_SRST_MAGIC);
        u_host.rd(`LMFR_OFS_PULL, d);
        chk(d, `LMFR_RST_PULL, "pull after soft reset");
        u_host.rd(`LMFR_OFS_CLK, d);
        chk(d, 8'h00, "clock after soft reset");
        step(2);
        chk({7'h00, sync_pd}, 8'h01, "sync after soft reset");
        $display("test soft reset done");
    endtask
    // slot lengths, order and duty share of the sinks
    task automatic t_scan;
        int hi, lo, sk, i;
        duty_i <= 8'h74;
        u_host.wr(`LMFR_OFS_CFG, 8'h09);
        for (i = 0; i < 1000 && scan_line === 11'h001; i++) step(1);
        for (i = 0; i < 12000 && scan_line !== 11'h001; i++) step(1);
        for (hi = 0; hi < 2000 && scan_line === 11'h001; hi++) begin
            sk += (sink_line === 6'h3F);
            step(1);
        end
        for (lo = 0; lo < 2000 && scan_line === 11'h000; lo++) step(1);
        chk_cnt(hi, `LMFR_SLOT_CYC, `LMFR_SLOT_CYC, "slot");
        chk_cnt(lo, `LMFR_GAP_CYC + `LMFR_DLY_CYC, `LMFR_GAP_CYC + `LMFR_DLY_CYC, "gap");
        chk(scan_line[7:0], 8'h02, "next line");
        chk_cnt(sk * 256, `LMFR_SLOT_CYC * 116 - 256, `LMFR_SLOT_CYC * 116 + 256, "duty");
        $display("test scan done");
    endtask
    // a slave with no sync edges holds its scan place
    task automatic t_slave;
        logic [10:0] held;
        u_host.wr(`LMFR_OFS_CLK, 8'h80);
        step(4);
        held = scan_line;
        step(100);
        chk(held[7:0], scan_line[7:0], "slave scan low");
        chk({5'h00, held[10:8]}, {5'h00, scan_line[10:8]}, "slave scan high");
        chk({6'h00, sync_oe, sync_pd}, 8'h00, "slave pins");
        u_host.wr(`LMFR_OFS_CLK, 8'h00);
        $display("test slave done");
    endtask
    // open then short pass; result bytes refuse writes
    task automatic t_detect;
        logic [7:0] d;
        fault_sense_i <= 6'h2A;
        u_host.detect(`LMFR_DET_OPEN);
        u_host.wr(`LMFR_OFS_RES_FIRST, 8'hFF);
        u_host.rd(`LMFR_OFS_RES_FIRST, d);
        chk(d, 8'h2A, "open first");
        u_host.rd(`LMFR_OFS_RES_LAST, d);
        chk(d, 8'h2A, "open last");
        fault_sense_i <= 6'h15;
        u_host.detect(`LMFR_DET_SHORT);
        u_host.rd(`LMFR_OFS_RES_LAST, d);
        chk(d, 8'h15, "short last");
        $display("test detect done");
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clock_i);
        nrst_i <= 1'b1;
        t_defaults();
        t_fields();
        t_soft_reset();
        t_scan();
        t_slave();
        t_detect();
        conclude();
    end
    // watchdog
    initial begin
        repeat (90000) @(posedge clock_i);
        n_mismatch++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        conclude();
    end
endmodule
`default_nettype wire
